/* hdl/scg_pkg.sv */
// Constants, register map and types for the system clock generator
package scg_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_DIVMUL = 8'hc7;
  localparam logic [7:0] ADDR_STATTB = 8'hbf;
  localparam logic [7:0] ADDR_SRCCTL = 8'h40;
  localparam logic [7:0] ADDR_MDIV = 8'h41;
  localparam logic [7:0] ADDR_PWRFLAG = 8'h97;
  localparam logic [7:0] ADDR_FLAGIE = 8'h8e;
  localparam logic [7:0] ADDR_PINCFG = 8'ha1;
  localparam logic [7:0] ADDR_SPEED = 8'h4c;
  // Reset values
  localparam logic [7:0] RST_DIVMUL = 8'h00;
  localparam logic [5:0] RST_TIMEBASE = 6'h0b;
  localparam logic [7:0] RST_SRCCTL = 8'h50;
  localparam logic [7:0] RST_MDIV = 8'h02;
  localparam logic [1:0] RST_MCD_EN = 2'h3;
  localparam logic [1:0] RST_SPEED = 2'h2;
  // Field positions
  localparam int BIT_ALT_FREQ = 7;
  localparam int BIT_MULT_EN = 6;
  localparam int BIT_CPU_HALF = 3;
  localparam int BIT_CRYSTAL_OSCILLATOR_READY = 7;
  localparam int BIT_CRYSTAL_OSCILLATOR_EN = 5;
  localparam int BIT_FAST_RC_EN = 4;
  localparam int BIT_MCD_FLAG = 5;
  localparam int BIT_MCD_RST_EN = 6;
  localparam int BIT_MCD_IRQ_EN = 5;
  localparam int BIT_HIGH_SPEED = 7;
  localparam int BIT_ULTRA_SPEED = 5;
  // Timing
  localparam int MULT_SETTLE_US = 100;
  localparam int MULT_SETTLE_CYCLES =
    (MULT_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MISS_TIME_NS = 2000;
  localparam int MISS_CYCLES = MISS_TIME_NS * 1000 / CLK_PERIOD_PS;
  localparam int CRYSTAL_OSCILLATOR_READY_EDGES = 1024;
  typedef enum logic [1:0] {
    OSC_FAST_RC = 2'b00,
    OSC_CRYSTAL = 2'b01,
    OSC_SLOW_RC = 2'b10,
    OSC_EXT_PIN = 2'b11
  } scg_osc_t;
  typedef enum logic [1:0] {
    MCK_OSC = 2'b00,
    MCK_X4 = 2'b01,
    MCK_X533 = 2'b10,
    MCK_X8 = 2'b11
  } scg_mck_t;
endpackage

/* hdl/scg_mon_if.sv */
// Interface between the clock generator and its crystal monitor
`timescale 1ns/1ns
`default_nettype none
interface scg_mon_if;
  logic xtalTick;
  logic enable;
  logic watch;
  logic ready;
  logic missing;
  modport mon (input xtalTick, enable, watch, output ready, missing);
  modport ctl (output xtalTick, enable, watch, input ready, missing);
endinterface
`default_nettype wire

/* hdl/scg_divider.sv */
// Power-of-two tick divider that changes ratio only at a period boundary
`timescale 1ns/1ns
`default_nettype none
module scg_divider #(
  parameter int CODE_W = 3
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Ticks
  input wire logic tickIn,
  input wire logic [CODE_W-1:0] code,
  output logic tickOut
);
  localparam int CNT_W = (1 << CODE_W) - 1;
  initial begin
    if (CODE_W < 1 || CODE_W > 3) $error("scg_divider: CODE_W 1..3");
  end
  logic [CNT_W-1:0] count;
  logic [CODE_W-1:0] activeCode;
  logic [CNT_W-1:0] limit;
  assign limit = CNT_W'((1 << activeCode) - 1);
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      activeCode <= '0;
      tickOut <= 1'b0;
    end else if (ce) begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (count >= limit) begin
          count <= '0;
          tickOut <= 1'b1;
          activeCode <= code; // Ratio swaps only at a whole period
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_div_pass;
    (ce && tickIn && activeCode == '0) |=> tickOut;
  endproperty
  a_div_pass: assert property (p_div_pass) else $error("div1 lost");
endmodule
`default_nettype wire

/* hdl/scg_crystal_oscillator_monitor.sv */
// Crystal start-up counter and missing-clock detector
`timescale 1ns/1ns
`default_nettype none
module scg_crystal_oscillator_monitor #(
  parameter int READY_EDGES = 1024,
  parameter int MISS_LIMIT = 500
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Monitor link
  scg_mon_if.mon mon
);
  initial begin
    if (READY_EDGES < 1 || MISS_LIMIT < 2) $error("scg_crystal_oscillator_monitor: range");
  end
  logic [$clog2(READY_EDGES+1)-1:0] edges;
  logic [$clog2(MISS_LIMIT+1)-1:0] gap;
  always_ff @(posedge clk) begin
    if (reset || (ce && !mon.enable)) begin
      edges <= '0;
      mon.ready <= 1'b0;
    end else if (ce && mon.xtalTick && !mon.ready) begin
      edges <= edges + 1'b1;
      mon.ready <= (edges == $bits(edges)'(READY_EDGES - 1));
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      gap <= '0;
      mon.missing <= 1'b0;
    end else if (ce) begin
      mon.missing <= 1'b0;
      if (!mon.watch || !mon.ready || mon.xtalTick) begin
        gap <= '0; // Detector idle unless watching a ready crystal
      end else if (gap == $bits(gap)'(MISS_LIMIT - 1)) begin
        gap <= '0;
        mon.missing <= 1'b1;
      end else begin
        gap <= gap + 1'b1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ready_needs_enable;
    $rose(mon.ready) |-> $past(mon.enable);
  endproperty
  a_ready_needs_enable: assert property (p_ready_needs_enable)
    else $error("ready without enable");
  property p_idle_detector;
    (ce && !mon.watch) |=> !mon.missing;
  endproperty
  a_idle_detector: assert property (p_idle_detector)
    else $error("detector fired while off");
endmodule
`default_nettype wire

/* hdl/scg_top.sv */
// System clock generator: source select, multiplier path, dividers, monitor
`timescale 1ns/1ns
`default_nettype none
module scg_top
  import scg_pkg::*;
#(
  parameter int MULT_SETTLE = scg_pkg::MULT_SETTLE_CYCLES,
  parameter int READY_EDGES = scg_pkg::CRYSTAL_OSCILLATOR_READY_EDGES,
  parameter int MISS_LIMIT = scg_pkg::MISS_CYCLES
) (
  // Clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // Source clock pins: fast RC, slow RC, crystal, external, x4, x5.33, x8
  input wire logic [6:0] srcClkPins,
  // Oscillator and multiplier controls
  output logic fastRcEnable,
  output logic rcAltFreq,
  output logic crystalEnable,
  output logic multEnable,
  output logic multInClk,
  // Generated clock enables
  output logic sysClkTick,
  output logic cpuClkTick,
  // Pad control
  output logic xtalPadsOwned,
  output logic extPinSelected,
  output logic clkOutEnable,
  output logic clkOutPin,
  // Speed and reset
  output logic highSpeed,
  output logic ultraSpeed,
  output logic mcdResetReq
);
  import scg_pkg::*;
  initial begin
    if (MULT_SETTLE < 1 || READY_EDGES < 1 || MISS_LIMIT < 2)
      $error("scg_top: bad parameter");
  end

  logic [7:0] divMul;
  logic [5:0] timebase;
  logic [7:0] srcCtl;
  logic [7:0] mdivReg;
  logic mcdFlag;
  logic [1:0] mcdEn;
  logic [1:0] pinCfg;
  logic [1:0] speed;
  logic [6:0] tick;
  scg_osc_t oscSel;
  scg_mck_t mckSel;
  logic oscTick, multInTick, masterTick, dmcTick, sysTick, cpuTick, outTick;
  logic [2:0] preCount;
  logic [$clog2(MULT_SETTLE+1)-1:0] lockCount;
  logic multLocked;
  logic [1:0] cpuCode;
  logic [1:0] outCode;
  scg_mon_if mon ();

  function automatic logic wr(input logic [7:0] a);
    return sfrWrite && sfrAddr == a;
  endfunction

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      divMul <= RST_DIVMUL;
      timebase <= RST_TIMEBASE;
      srcCtl <= RST_SRCCTL;
      mdivReg <= RST_MDIV;
      mcdEn <= RST_MCD_EN;
      pinCfg <= 2'h0;
      speed <= RST_SPEED;
    end else if (ce) begin
      if (wr(ADDR_DIVMUL)) divMul <= sfrWdata;
      if (wr(ADDR_STATTB)) timebase <= sfrWdata[5:0];
      if (wr(ADDR_SRCCTL)) srcCtl <= sfrWdata;
      if (wr(ADDR_MDIV)) mdivReg <= sfrWdata;
      if (wr(ADDR_FLAGIE)) mcdEn <= sfrWdata[BIT_MCD_RST_EN -: 2];
      if (wr(ADDR_PINCFG)) pinCfg <= sfrWdata[7:6];
      if (wr(ADDR_SPEED)) begin
        speed <= {sfrWdata[BIT_HIGH_SPEED], sfrWdata[BIT_ULTRA_SPEED]};
      end
    end
  end

  // Missing-clock flag: a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      mcdFlag <= 1'b0;
    end else if (ce) begin
      mcdFlag <= (mcdFlag & ~(wr(ADDR_PWRFLAG) & sfrWdata[BIT_MCD_FLAG]))
                 | mon.missing;
    end
  end

  // Register reads, answered one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      sfrRdata <= 8'h00;
    end else if (ce && sfrRead) begin
      case (sfrAddr)
        ADDR_DIVMUL: sfrRdata <= divMul;
        ADDR_STATTB: sfrRdata <= {mon.ready, 1'b0, timebase};
        ADDR_SRCCTL: sfrRdata <= srcCtl;
        ADDR_MDIV: sfrRdata <= mdivReg;
        ADDR_PWRFLAG: sfrRdata <= {2'h0, mcdFlag, 5'h00};
        ADDR_FLAGIE: sfrRdata <= {1'b0, mcdEn, 5'h00};
        ADDR_PINCFG: sfrRdata <= {pinCfg, 6'h00};
        ADDR_SPEED: sfrRdata <= {speed[1], 1'b0, speed[0], 5'h00};
        default: sfrRdata <= 8'h00;
      endcase
    end
  end

  // Source pins pass three flops; edge taken between second and third
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : gSync
      logic stage1, stage2, stage3;
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
        end else if (ce) begin
          stage1 <= srcClkPins[g];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end
      assign tick[g] = ce & stage2 & ~stage3;
    end
  endgenerate

  assign oscSel = scg_osc_t'(srcCtl[1:0]);
  assign mckSel = scg_mck_t'(srcCtl[3:2]);

  // Oscillator input mux
  always_comb begin
    case (oscSel)
      OSC_FAST_RC: oscTick = tick[0];
      OSC_CRYSTAL: oscTick = tick[2];
      OSC_SLOW_RC: oscTick = tick[1];
      OSC_EXT_PIN: oscTick = tick[3];
      default: oscTick = tick[0];
    endcase
  end

  // Multiplier input prescaler: /1, /2, /4, /6
  always_ff @(posedge clk) begin
    if (reset) begin
      preCount <= 3'h0;
      multInTick <= 1'b0;
      multInClk <= 1'b0;
    end else if (ce) begin
      multInTick <= 1'b0;
      if (oscTick) begin
        if (preCount >= (divMul[5:4] == 2'h3 ? 3'h5 :
            3'((1 << divMul[5:4]) - 1))) begin
          preCount <= 3'h0;
          multInTick <= 1'b1;
          multInClk <= ~multInClk;
        end else begin
          preCount <= preCount + 3'h1;
        end
      end
    end
  end

  // Multiplier settle timer; restarts whenever the multiplier is off
  always_ff @(posedge clk) begin
    if (reset || (ce && !divMul[BIT_MULT_EN])) begin
      lockCount <= '0;
      multLocked <= 1'b0;
    end else if (ce && !multLocked) begin
      lockCount <= lockCount + 1'b1;
      multLocked <= (lockCount == $bits(lockCount)'(MULT_SETTLE - 1));
    end
  end

  // Master clock mux; multiplier outputs only once settled
  always_comb begin
    case (multLocked ? mckSel : MCK_OSC)
      MCK_OSC: masterTick = oscTick;
      MCK_X4: masterTick = tick[4];
      MCK_X533: masterTick = tick[5];
      MCK_X8: masterTick = tick[6];
      default: masterTick = oscTick;
    endcase
  end

  assign cpuCode = {1'b0, divMul[BIT_CPU_HALF]};
  assign outCode = pinCfg - 2'h1;

  scg_divider #(.CODE_W(2)) uMasterDiv (
    .clk(clk), .reset(reset), .ce(ce),
    .tickIn(masterTick), .code(mdivReg[3:2]), .tickOut(dmcTick)
  );
  scg_divider #(.CODE_W(3)) uSysDiv (
    .clk(clk), .reset(reset), .ce(ce),
    .tickIn(dmcTick), .code(divMul[2:0]), .tickOut(sysTick)
  );
  scg_divider #(.CODE_W(2)) uCpuDiv (
    .clk(clk), .reset(reset), .ce(ce),
    .tickIn(sysTick), .code(cpuCode), .tickOut(cpuTick)
  );
  scg_divider #(.CODE_W(2)) uOutDiv (
    .clk(clk), .reset(reset), .ce(ce),
    .tickIn(masterTick), .code(outCode), .tickOut(outTick)
  );

  assign mon.xtalTick = tick[2];
  assign mon.enable = crystalEnable;
  assign mon.watch = mcdEn[0] && crystalEnable && oscSel == OSC_CRYSTAL;
  scg_crystal_oscillator_monitor #(.READY_EDGES(READY_EDGES), .MISS_LIMIT(MISS_LIMIT))
    uMon (.clk(clk), .reset(reset), .ce(ce), .mon(mon));

  // Registered outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      fastRcEnable <= 1'b1;
      rcAltFreq <= 1'b0;
      crystalEnable <= 1'b0;
      multEnable <= 1'b0;
      sysClkTick <= 1'b0;
      cpuClkTick <= 1'b0;
      xtalPadsOwned <= 1'b0;
      extPinSelected <= 1'b0;
      clkOutEnable <= 1'b0;
      clkOutPin <= 1'b0;
      highSpeed <= 1'b1;
      ultraSpeed <= 1'b0;
      mcdResetReq <= 1'b0;
    end else if (ce) begin
      fastRcEnable <= srcCtl[BIT_FAST_RC_EN];
      rcAltFreq <= divMul[BIT_ALT_FREQ];
      crystalEnable <= srcCtl[BIT_CRYSTAL_OSCILLATOR_EN];
      multEnable <= divMul[BIT_MULT_EN];
      sysClkTick <= sysTick;
      cpuClkTick <= cpuTick;
      xtalPadsOwned <= srcCtl[BIT_CRYSTAL_OSCILLATOR_EN] || oscSel == OSC_CRYSTAL;
      extPinSelected <= oscSel == OSC_EXT_PIN;
      clkOutEnable <= pinCfg != 2'h0 && !srcCtl[BIT_CRYSTAL_OSCILLATOR_EN] &&
        (oscSel == OSC_FAST_RC || oscSel == OSC_SLOW_RC);
      if (outTick) clkOutPin <= ~clkOutPin;
      highSpeed <= speed[1];
      ultraSpeed <= speed[0];
      mcdResetReq <= mon.missing && mcdEn[1];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_crystal_oscillator_chosen;
    ce && oscSel == OSC_CRYSTAL;
  endsequence
  sequence s_pads_follow;
    ##1 (!ce || xtalPadsOwned);
  endsequence
  property p_boot;
    $fell(reset) |-> (oscSel == OSC_FAST_RC && !xtalPadsOwned);
  endproperty
  a_boot: assert property (p_boot) else $error("not booted on fast RC");
  property p_pads;
    s_crystal_oscillator_chosen |-> s_pads_follow;
  endproperty
  a_pads: assert property (p_pads) else $error("pads not handed over");
  property p_ext;
    (ce && oscSel == OSC_EXT_PIN) |->
      (oscTick == tick[3]) ##1 (!ce || extPinSelected);
  endproperty
  a_ext: assert property (p_ext) else $error("ext pin not used");
  property p_hold_unlocked;
    !multLocked |-> masterTick == oscTick;
  endproperty
  a_hold_unlocked: assert property (p_hold_unlocked)
    else $error("multiplier used before settling");
  property p_flag_set;
    mon.missing && ce |=> mcdFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag lost");
  property p_mcd_reset;
    (ce && mon.missing) |=> mcdResetReq == $past(mcdEn[1]);
  endproperty
  a_mcd_reset: assert property (p_mcd_reset) else $error("reset req");
  property p_ready_off;
    (ce && !crystalEnable) [*2] |=> !mon.ready;
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready w/o crystal_oscillator");
  property p_clkout_crystal_oscillator;
    crystalEnable |-> ##1 (!ce || !clkOutEnable || !srcCtl[BIT_CRYSTAL_OSCILLATOR_EN]);
  endproperty
  a_clkout_crystal_oscillator: assert property (p_clkout_crystal_oscillator)
    else $error("clock out under crystal");
endmodule
`default_nettype wire

/* dv/scg_src_model.sv */
// Behavioural source clocks: RC oscillators, crystal, external pin, multiplier
`timescale 1ns/1ns
`default_nettype none
module scg_src_model (
  // Control
  input wire logic crystalEnable,
  input wire logic crystalRun,
  // Source levels
  output logic [6:0] srcClkPins
);
  logic fastRc = 1'b0;
  logic slowRc = 1'b0;
  logic crystal_oscillator = 1'b0;
  logic extPin = 1'b0;
  logic x4 = 1'b0;
  logic x533 = 1'b0;
  logic x8 = 1'b0;
  // Half periods are whole multiples of the 4 ns system clock
  always #20 fastRc = ~fastRc;
  always #60 slowRc = ~slowRc;
  // A stopped or disabled crystal holds its last level: no edges at all
  always #28 if (crystalEnable && crystalRun) crystal_oscillator = ~crystal_oscillator;
  always #36 extPin = ~extPin;
  always #16 x4 = ~x4;
  always #12 x533 = ~x533;
  always #8 x8 = ~x8;
  assign srcClkPins = {x8, x533, x4, extPin, crystal_oscillator, slowRc, fastRc};
endmodule
`default_nettype wire

/* dv/scg_testbench.sv */
// Self-checking bench for the system clock generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin \
  n_tests++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); \
  end \
end
module testbench;
  import scg_pkg::*;
  logic clk, reset, ce, sfrWrite, sfrRead, crystalRun;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, rdv;
  logic [6:0] srcClkPins;
  logic fastRcEnable, rcAltFreq, crystalEnable, multEnable, multInClk;
  logic sysClkTick, cpuClkTick, xtalPadsOwned, extPinSelected;
  logic clkOutEnable, clkOutPin, highSpeed, ultraSpeed, mcdResetReq;
  int err_count = 0;
  int n_tests = 0;
  int cyc;
  logic seen;
  int dv[4] = '{1, 2, 4, 6};
  int mk[4] = '{10, 8, 6, 4};
  localparam int OSC = 10;

  scg_top #(.MULT_SETTLE(20), .READY_EDGES(4), .MISS_LIMIT(20)) scg_top_i (
    .clk(clk), .reset(reset), .ce(ce), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .srcClkPins(srcClkPins),
    .fastRcEnable(fastRcEnable), .rcAltFreq(rcAltFreq),
    .crystalEnable(crystalEnable), .multEnable(multEnable),
    .multInClk(multInClk), .sysClkTick(sysClkTick),
    .cpuClkTick(cpuClkTick), .xtalPadsOwned(xtalPadsOwned),
    .extPinSelected(extPinSelected), .clkOutEnable(clkOutEnable),
    .clkOutPin(clkOutPin), .highSpeed(highSpeed), .ultraSpeed(ultraSpeed),
    .mcdResetReq(mcdResetReq));
  scg_src_model scg_src_model_i (
    .crystalEnable(crystalEnable), .crystalRun(crystalRun),
    .srcClkPins(srcClkPins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
    // Registered outputs follow the register one cycle later
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk);
    sfrRead = 1'b0;
    @(negedge clk);
    rdv = sfrRdata;
  endtask

  task automatic chkrd(input string nm, input logic [7:0] a,
                       input logic [7:0] m, input logic [7:0] ex);
    rd(a);
    `CHK(nm, ex, rdv & m)
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return sysClkTick;
      1: return cpuClkTick;
      2: return multInClk;
      default: return clkOutPin;
    endcase
  endfunction

  // Interval between the 3rd and 4th event, so ratio changes have landed
  task automatic per(input string nm, input int sel, input int ex);
    int n;
    int last;
    int hits;
    logic prev;
    logic cur;
    n = 0;
    last = 0;
    hits = 0;
    cyc = 0;
    prev = pick(sel);
    while (hits < 4 && n < 8000) begin
      @(negedge clk);
      n++;
      cur = pick(sel);
      if (sel < 2 ? cur === 1'b1 : cur !== prev) begin
        hits++;
        if (hits == 4) cyc = n - last;
        last = n;
      end
      prev = cur;
    end
    `CHK(nm, ex, cyc)
  endtask

  task automatic wpulse(input int maxc);
    seen = 1'b0;
    repeat (maxc) begin
      @(negedge clk);
      if (mcdResetReq === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic crystal_oscillator_up();
    int n;
    n = 0;
    wr(ADDR_SRCCTL, 8'h70);
    rdv = 8'h00;
    while (rdv[7] !== 1'b1 && n < 100) begin
      rd(ADDR_STATTB);
      n++;
    end
    `CHK("ready", 1'b1, rdv[7])
    wr(ADDR_SRCCTL, 8'h71);
    repeat (10) @(negedge clk);
  endtask

  task automatic crystal_oscillator_down();
    wr(ADDR_SRCCTL, 8'h70);
    repeat (10) @(negedge clk);
    wr(ADDR_SRCCTL, 8'h50);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    crystalRun = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    `CHK("fastRcEnable", 1'b1, fastRcEnable)
    `CHK("padsOwned", 1'b0, xtalPadsOwned)
    `CHK("extPin", 1'b0, extPinSelected)
    `CHK("crystalEnable", 1'b0, crystalEnable)
    chkrd("stat", ADDR_STATTB, 8'hff, 8'h0b);
    chkrd("srcctl", ADDR_SRCCTL, 8'hff, 8'h50);
    chkrd("mdiv", ADDR_MDIV, 8'h0c, 8'h00);
    chkrd("divmul", ADDR_DIVMUL, 8'hff, 8'h00);
    chkrd("flagie", ADDR_FLAGIE, 8'h60, 8'h60);
    chkrd("pwrflag", ADDR_PWRFLAG, 8'h20, 8'h00);
    chkrd("unmapped", 8'h55, 8'hff, 8'h00);
    per("sysBoot", 0, OSC);
    wr(ADDR_DIVMUL, 8'h80);
    `CHK("altFreq", 1'b1, rcAltFreq)
    `CHK("multOff", 1'b0, multEnable)
    wr(ADDR_DIVMUL, 8'h40);
    `CHK("altFreq0", 1'b0, rcAltFreq)
    `CHK("multOn", 1'b1, multEnable)
    chkrd("divmulRb", ADDR_DIVMUL, 8'hff, 8'h40);
    wr(ADDR_STATTB, 8'hbf);
    chkrd("readyRo", ADDR_STATTB, 8'hff, 8'h3f);
    wr(ADDR_STATTB, 8'h0b);
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_DIVMUL, 8'(k));
      per("sysDiv", 0, OSC << k);
    end
    wr(ADDR_DIVMUL, 8'h08);
    per("cpuHalf", 1, 2 * OSC);
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_MDIV, {4'h0, 2'(k), 2'b10});
      per("mckDiv", 0, OSC << k);
    end
    wr(ADDR_MDIV, 8'h02);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_DIVMUL, {2'b00, 2'(k), 4'h8});
      wr(ADDR_DIVMUL, {2'b01, 2'(k), 4'h8});
      per("multIn", 2, OSC * dv[k]);
    end
    wr(ADDR_SPEED, 8'ha0);
    `CHK("highSpeed", 1'b1, highSpeed)
    `CHK("ultraSpeed", 1'b1, ultraSpeed)
    wr(ADDR_DIVMUL, 8'h58);
    repeat (30) @(negedge clk);
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_SRCCTL, 8'h50 | 8'(k << 2));
      per("mckSel", 0, mk[k]);
      per("cpuMult", 1, 2 * mk[k]);
    end
    wr(ADDR_SRCCTL, 8'h50);
    wr(ADDR_DIVMUL, 8'h00);
    wr(ADDR_SRCCTL, 8'h52);
    per("slowRc", 0, 30);
    wr(ADDR_SRCCTL, 8'h53);
    per("extClk", 0, 18);
    `CHK("extSel", 1'b1, extPinSelected)
    `CHK("extPads", 1'b0, xtalPadsOwned)
    wr(ADDR_SRCCTL, 8'h50);
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_PINCFG, {2'(k), 6'h00});
      `CHK("clkOutEn", 1'b1, clkOutEnable)
      per("clkOut", 3, OSC << (k - 1));
    end
    crystal_oscillator_up();
    `CHK("xtalPads", 1'b1, xtalPadsOwned)
    `CHK("clkOutXtal", 1'b0, clkOutEnable)
    per("xtalSys", 0, 14);
    crystalRun = 1'b0;
    wpulse(60);
    `CHK("mcdReset", 1'b1, seen)
    chkrd("mcdFlag", ADDR_PWRFLAG, 8'h20, 8'h20);
    // Restart the crystal first so no new event lands on the clear
    crystalRun = 1'b1;
    repeat (30) @(negedge clk);
    wr(ADDR_PWRFLAG, 8'h20);
    chkrd("mcdClr", ADDR_PWRFLAG, 8'h20, 8'h00);
    crystal_oscillator_down();
    chkrd("readyOff", ADDR_STATTB, 8'h80, 8'h00);
    wr(ADDR_FLAGIE, 8'h20);
    crystal_oscillator_up();
    crystalRun = 1'b0;
    wpulse(60);
    `CHK("mcdNoReset", 1'b0, seen)
    chkrd("mcdFlag2", ADDR_PWRFLAG, 8'h20, 8'h20);
    crystalRun = 1'b1;
    repeat (30) @(negedge clk);
    wr(ADDR_PWRFLAG, 8'h20);
    crystal_oscillator_down();
    wr(ADDR_FLAGIE, 8'h00);
    crystal_oscillator_up();
    crystalRun = 1'b0;
    wpulse(60);
    `CHK("mcdOffRst", 1'b0, seen)
    chkrd("mcdOff", ADDR_PWRFLAG, 8'h20, 8'h00);
    crystalRun = 1'b1;
    crystal_oscillator_down();
    final_report();
  end
endmodule
`default_nettype wire
